// file: inc/mch_pkg.sv
/*
 * Constants, field layout and helpers for the memory controller capability
 * header block. Assumes a single configuration clock and that the host
 * presents one configuration access per request strobe.
 */
// Overview of operation
// - Pointer register reads 40h.
// - Header bits 7:0 read 10h.
// - Next-capability link reads zero; list ends.
// - Capability version field reads 1.
// - Port type reads 9, integrated endpoint.
// - Slot implemented bit reads zero.
// - Interrupt message number reads zero.
// - Structure spans three dwords only.
// - Device 10 is controller 0, 12 controller 1.
package mch_pkg;

    // ------------------------------------------------------------
    // Claimed configuration addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  MCH_CFG_BUS      = 8'h02;
    localparam logic [4:0]  MCH_DEV_MC0      = 5'h0a;
    localparam logic [4:0]  MCH_DEV_MC1      = 5'h0c;
    localparam logic [2:0]  MCH_CFG_FUNC     = 3'h0;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] MCH_OFF_CAP_PTR  = 12'h034;
    localparam logic [11:0] MCH_OFF_CAP_HDR  = 12'h040;
    localparam logic [11:0] MCH_OFF_EXT_BASE = 12'h100;
    localparam logic [9:0]  MCH_CAP_DWORDS   = 10'h003;

    // ------------------------------------------------------------
    // Field values and positions
    // ------------------------------------------------------------
    localparam logic [7:0]  MCH_CAP_PTR_VAL  = 8'h40;
    localparam logic [7:0]  MCH_CAP_ID_VAL   = 8'h10;
    localparam logic [7:0]  MCH_NEXT_PTR_VAL = 8'h00;
    localparam logic [3:0]  MCH_CAP_VER_VAL  = 4'h1;
    localparam logic [3:0]  MCH_PORT_TYPE    = 4'h9;
    localparam logic        MCH_SLOT_VAL     = 1'b0;
    localparam logic [4:0]  MCH_INT_MSG_VAL  = 5'h00;
    localparam int          MCH_ID_LSB       = 0;
    localparam int          MCH_NEXT_LSB     = 8;
    localparam int          MCH_VER_LSB      = 16;
    localparam int          MCH_TYPE_LSB     = 20;
    localparam int          MCH_SLOT_BIT     = 24;
    localparam int          MCH_MSG_LSB      = 25;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] MCH_RDATA_RST    = 32'h0000_0000;
    localparam int          MCH_RD_LATENCY   = 2;

    // Header word; bits 31:30 stay zero
    function automatic logic [31:0] mch_cap_header();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[MCH_ID_LSB+:8]   = MCH_CAP_ID_VAL;
        w[MCH_NEXT_LSB+:8] = MCH_NEXT_PTR_VAL;
        w[MCH_VER_LSB+:4]  = MCH_CAP_VER_VAL;
        w[MCH_TYPE_LSB+:4] = MCH_PORT_TYPE;
        w[MCH_SLOT_BIT]    = MCH_SLOT_VAL;
        w[MCH_MSG_LSB+:5]  = MCH_INT_MSG_VAL;
        return w;
    endfunction

    // Bus and function match for either controller
    function automatic logic mch_fn_match(input logic [7:0] bus, input logic [2:0] func);
        return (bus == MCH_CFG_BUS) && (func == MCH_CFG_FUNC);
    endfunction

endpackage

// file: core/mch_cap_rom.sv
/*
 * Capability read-only store for one controller function.
 * Assumes the caller raises rd_en only for reads aimed at this function.
 */
`timescale 1ns/1ps
module mch_cap_rom (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Read port
    input  wire logic        rd_en,
    input  wire logic [9:0]  dw_addr,
    output logic      [31:0] rdata_q
);
    import mch_pkg::*;

    // ------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = MCH_RDATA_RST;
        if (rd_en) begin
            if (dw_addr == MCH_OFF_CAP_PTR[11:2]) begin
                rdata_d = {24'h000000, MCH_CAP_PTR_VAL};
            end else if (dw_addr == MCH_OFF_CAP_HDR[11:2]) begin
                rdata_d = mch_cap_header();
            end
            // Remaining structure dwords and all other space read zero
        end
    end

    // Idle output is zero so the two stores can be merged with an OR
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= MCH_RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

endmodule // mch_cap_rom

// file: core/mch_cfg_header.sv
/*
 * Configuration-space capability header for two memory controller functions.
 * Assumes the host drives one access per cfg_req cycle on sys_clk and that
 * extended space is used only by firmware or a management controller.
 */
`timescale 1ns/1ps
module mch_cfg_header (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Configuration request
    input  wire logic        cfg_req,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_bus,
    input  wire logic [4:0]  cfg_dev,
    input  wire logic [2:0]  cfg_func,
    input  wire logic [11:0] cfg_offset,
    // Configuration answer
    output logic             cfg_ack,
    output logic             cfg_hit,
    output logic             cfg_mc_sel,
    output logic      [31:0] cfg_rdata
);
    import mch_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic        hit_mc0;
    logic        hit_mc1;
    logic        req_hit;
    logic        rd_mc0;
    logic        rd_mc1;

    assign hit_mc0 = mch_fn_match(cfg_bus, cfg_func) && (cfg_dev == MCH_DEV_MC0);
    assign hit_mc1 = mch_fn_match(cfg_bus, cfg_func) && (cfg_dev == MCH_DEV_MC1);
    assign req_hit = hit_mc0 || hit_mc1;
    // Writes never reach the stores, so nothing can change
    assign rd_mc0  = cfg_req && !cfg_wr && hit_mc0;
    assign rd_mc1  = cfg_req && !cfg_wr && hit_mc1;

    // ------------------------------------------------------------
    // Per-function stores
    // ------------------------------------------------------------
    logic [31:0] rom0_rdata;
    logic [31:0] rom1_rdata;

    mch_cap_rom u_rom_mc0 (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .rd_en   (rd_mc0),
        .dw_addr (cfg_offset[11:2]),
        .rdata_q (rom0_rdata)
    );

    mch_cap_rom u_rom_mc1 (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .rd_en   (rd_mc1),
        .dw_addr (cfg_offset[11:2]),
        .rdata_q (rom1_rdata)
    );

    // ------------------------------------------------------------
    // Stage one: request tracking
    // ------------------------------------------------------------
    logic        s1_vld_q;
    logic        s1_hit_q;
    logic        s1_mc_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_vld_q <= 1'b0;
            s1_hit_q <= 1'b0;
            s1_mc_q  <= 1'b0;
        end else begin
            s1_vld_q <= cfg_req;
            s1_hit_q <= cfg_req && req_hit;
            s1_mc_q  <= cfg_req && hit_mc1;
        end
    end

    // ------------------------------------------------------------
    // Stage two: answer registers
    // ------------------------------------------------------------
    logic        ack_q;
    logic        hit_q;
    logic        mc_q;
    logic [31:0] rdata_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            hit_q <= 1'b0;
            mc_q  <= 1'b0;
        end else begin
            ack_q <= s1_vld_q;
            hit_q <= s1_hit_q;
            mc_q  <= s1_mc_q;
        end
    end

    // Idle stores return zero, so misses and writes read as zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= MCH_RDATA_RST;
        end else begin
            rdata_q <= rom0_rdata | rom1_rdata;
        end
    end

    assign cfg_ack    = ack_q;
    assign cfg_hit    = hit_q;
    assign cfg_mc_sel = mc_q;
    assign cfg_rdata  = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    logic        rd_ptr;
    logic        rd_hdr;
    logic        rd_tail;
    assign rd_ptr  = cfg_req && !cfg_wr && req_hit && (cfg_offset[11:2] == MCH_OFF_CAP_PTR[11:2]);
    assign rd_hdr  = cfg_req && !cfg_wr && req_hit && (cfg_offset[11:2] == MCH_OFF_CAP_HDR[11:2]);
    assign rd_tail = cfg_req && !cfg_wr && req_hit && (cfg_offset[11:2] > MCH_OFF_CAP_HDR[11:2]);

    sequence s_hdr_ans;
        ##2 cfg_ack && cfg_hit;
    endsequence

    property p_cap_ptr;
        rd_ptr |-> ##2 (cfg_ack && cfg_rdata == 32'h0000_0040);
    endproperty
    a_cap_ptr: assert property (p_cap_ptr) else $error("pointer register not 40h");

    property p_cap_id;
        rd_hdr |-> s_hdr_ans ##0 (cfg_rdata[7:0] == 8'h10);
    endproperty
    a_cap_id: assert property (p_cap_id) else $error("capability_identifier wrong");

    property p_next_ptr;
        rd_hdr |-> s_hdr_ans ##0 (cfg_rdata[15:8] == 8'h00);
    endproperty
    a_next_ptr: assert property (p_next_ptr) else $error("next pointer not zero");

    property p_cap_ver;
        rd_hdr |-> s_hdr_ans ##0 (cfg_rdata[19:16] == 4'h1);
    endproperty
    a_cap_ver: assert property (p_cap_ver) else $error("capability version wrong");

    property p_port_type;
        rd_hdr |-> s_hdr_ans ##0 (cfg_rdata[23:20] == 4'h9);
    endproperty
    a_port_type: assert property (p_port_type) else $error("port type wrong");

    property p_slot;
        rd_hdr |-> ##2 !cfg_rdata[24];
    endproperty
    a_slot: assert property (p_slot) else $error("slot bit set");

    property p_int_msg;
        rd_hdr |-> ##2 (cfg_rdata[31:25] == 7'h00);
    endproperty
    a_int_msg: assert property (p_int_msg) else $error("message number or upper bits not zero");

    property p_tail_zero;
        rd_tail |-> ##2 (cfg_ack && cfg_rdata == 32'h0000_0000);
    endproperty
    a_tail_zero: assert property (p_tail_zero) else $error("space past header not zero");

    property p_dev_map;
        cfg_req |-> ##2 (cfg_ack && cfg_hit == $past(req_hit, 2) && cfg_mc_sel == $past(hit_mc1, 2));
    endproperty
    a_dev_map: assert property (p_dev_map) else $error("device mapping wrong");

    // A write must never enable a store read, or it could leak data into the answer
    property p_wr_ignored;
        (cfg_req && cfg_wr) |-> (!rd_mc0 && !rd_mc1) ##2 (cfg_ack && cfg_rdata == 32'h0000_0000);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("write had an effect");

    property p_no_spurious_ack;
        !cfg_req |-> ##2 !cfg_ack;
    endproperty
    a_no_spurious_ack: assert property (p_no_spurious_ack) else $error("answer without request");

    property p_miss_zero;
        (cfg_req && !req_hit) |-> ##2 (cfg_ack && !cfg_hit && !cfg_mc_sel && cfg_rdata == 32'h0000_0000);
    endproperty
    a_miss_zero: assert property (p_miss_zero) else $error("unclaimed access answered with data");

    property p_sel_needs_hit;
        cfg_mc_sel |-> cfg_hit;
    endproperty
    a_sel_needs_hit: assert property (p_sel_needs_hit) else $error("controller select without hit");

    // Whole header word at once, so a stray upper bit cannot hide between fields
    property p_hdr_word;
        rd_hdr |-> s_hdr_ans ##0 (cfg_rdata == 32'h0091_0010);
    endproperty
    a_hdr_word: assert property (p_hdr_word) else $error("header word wrong");

    // Merged answer path relies on idle stores returning zero
    property p_idle_rdata;
        !cfg_ack |-> (cfg_rdata == 32'h0000_0000);
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data without answer");

    c_hdr_mc0: cover property (rd_hdr && hit_mc0 ##2 cfg_ack);
    c_hdr_mc1: cover property (rd_hdr && hit_mc1 ##2 cfg_ack);
    c_write:   cover property (cfg_req && cfg_wr && req_hit ##2 cfg_ack);
    c_miss:    cover property (cfg_req && !req_hit ##2 (cfg_ack && !cfg_hit));
    c_b2b:     cover property (cfg_ack ##1 cfg_ack);

endmodule // mch_cfg_header

// file: verification/mch_cfg_header_tb.sv
/*
 * Self-checking testbench for the memory controller capability header block.
 * Assumes the block answers each configuration access exactly two cycles after
 * the taking edge, and that its assertions live in the design files.
 */
`timescale 1ns/1ps
module mch_cfg_header_tb;
    import mch_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        sys_clk;
    logic        rst_b;
    logic        cfg_req;
    logic        cfg_wr;
    logic [7:0]  cfg_bus;
    logic [4:0]  cfg_dev;
    logic [2:0]  cfg_func;
    logic [11:0] cfg_offset;
    logic        cfg_ack;
    logic        cfg_hit;
    logic        cfg_mc_sel;
    logic [31:0] cfg_rdata;
    logic [31:0] got_rd;
    logic        got_hit;
    logic        got_sel;
    int          num_errors;
    int          compares;

    // Header built field by field: id, next, version, type, slot, message, top
    localparam logic [31:0] HDR_EXP = {2'b00, 5'h00, 1'b0, 4'h9, 4'h1, 8'h00, 8'h10};

    mch_cfg_header u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_bus(cfg_bus), .cfg_dev(cfg_dev), .cfg_func(cfg_func), .cfg_offset(cfg_offset),
        .cfg_ack(cfg_ack), .cfg_hit(cfg_hit), .cfg_mc_sel(cfg_mc_sel), .cfg_rdata(cfg_rdata));

    always #5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic put(input logic wr, input logic [4:0] dev, input logic [11:0] off,
                       input logic [7:0] bus = 8'h02, input logic [2:0] fn = 3'h0);
        cfg_req    <= 1'b1;
        cfg_wr     <= wr;
        cfg_bus    <= bus;
        cfg_dev    <= dev;
        cfg_func   <= fn;
        cfg_offset <= off;
    endtask

    // One access; the answer must come exactly two edges after the taking edge
    task automatic acc(input logic wr, input logic [4:0] dev, input logic [11:0] off,
                       input logic [7:0] bus = 8'h02, input logic [2:0] fn = 3'h0);
        int n;
        @(posedge sys_clk);
        put(wr, dev, off, bus, fn);
        @(posedge sys_clk);
        cfg_req <= 1'b0;
        // n is the edge, counted from the taking edge, that samples the answer
        for (n = 2; n <= 5; n++) begin
            @(posedge sys_clk);
            #1;
            if (cfg_ack === 1'b1) break;
        end
        if (n > 5) begin
            num_errors++;
            final_report();
        end
        chk("latency", 32'h2, 32'(n));
        got_rd  = cfg_rdata;
        got_hit = cfg_hit;
        got_sel = cfg_mc_sel;
    endtask

    task automatic ans(input logic hit, input logic sel, input logic [31:0] rd);
        chk("hit", {31'h0, hit}, {31'h0, got_hit});
        chk("mc_sel", {31'h0, sel}, {31'h0, got_sel});
        chk("rdata", rd, got_rd);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        cfg_req = 1'b0;
        cfg_wr = 1'b0;
        cfg_bus = 8'h00;
        cfg_dev = 5'h00;
        cfg_func = 3'h0;
        cfg_offset = 12'h000;
        num_errors = 0;
        compares = 0;
        repeat (8) @(posedge sys_clk);
        #1;
        chk("ack_in_reset", 32'h0, {31'h0, cfg_ack});
        chk("rdata_in_reset", 32'h0, cfg_rdata);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        // Pointer and header on both controllers
        acc(1'b0, 5'h0a, 12'h034); ans(1'b1, 1'b0, 32'h0000_0040);
        acc(1'b0, 5'h0c, 12'h034); ans(1'b1, 1'b1, 32'h0000_0040);
        acc(1'b0, 5'h0c, 12'h040); ans(1'b1, 1'b1, HDR_EXP);
        acc(1'b0, 5'h0a, 12'h040); ans(1'b1, 1'b0, HDR_EXP);
        chk("cap_id", 32'h10, {24'h0, got_rd[7:0]});
        chk("next_ptr", 32'h0, {24'h0, got_rd[15:8]});
        chk("cap_version", 32'h1, {28'h0, got_rd[19:16]});
        chk("port_type", 32'h9, {28'h0, got_rd[23:20]});
        chk("slot_impl", 32'h0, {31'h0, got_rd[24]});
        chk("int_msg_num", 32'h0, {27'h0, got_rd[29:25]});
        chk("upper_bits", 32'h0, {30'h0, got_rd[31:30]});
        // Low offset bits are ignored
        acc(1'b0, 5'h0a, 12'h043); ans(1'b1, 1'b0, HDR_EXP);
        // Rest of the structure and extended space read zero
        acc(1'b0, 5'h0a, 12'h044); ans(1'b1, 1'b0, 32'h0);
        acc(1'b0, 5'h0c, 12'h048); ans(1'b1, 1'b1, 32'h0);
        acc(1'b0, 5'h0c, 12'h100); ans(1'b1, 1'b1, 32'h0);
        // Writes return no data and change nothing
        acc(1'b1, 5'h0a, 12'h040); ans(1'b1, 1'b0, 32'h0);
        acc(1'b1, 5'h0c, 12'h034); ans(1'b1, 1'b1, 32'h0);
        acc(1'b0, 5'h0a, 12'h040); ans(1'b1, 1'b0, HDR_EXP);
        acc(1'b0, 5'h0c, 12'h034); ans(1'b1, 1'b1, 32'h0000_0040);
        // Neighbouring device, bus and function numbers are not claimed
        acc(1'b0, 5'h0b, 12'h040); ans(1'b0, 1'b0, 32'h0);
        acc(1'b0, 5'h0c, 12'h040, 8'h03); ans(1'b0, 1'b0, 32'h0);
        acc(1'b0, 5'h0a, 12'h034, 8'h02, 3'h1); ans(1'b0, 1'b0, 32'h0);
        // Back to back: answers in order, each standing one cycle only
        @(posedge sys_clk);
        put(1'b0, 5'h0c, 12'h040);
        @(posedge sys_clk);
        put(1'b0, 5'h0a, 12'h034);
        @(posedge sys_clk);
        cfg_req <= 1'b0;
        #1;
        got_rd = cfg_rdata; got_hit = cfg_hit; got_sel = cfg_mc_sel;
        ans(1'b1, 1'b1, HDR_EXP);
        @(posedge sys_clk);
        #1;
        got_rd = cfg_rdata; got_hit = cfg_hit; got_sel = cfg_mc_sel;
        ans(1'b1, 1'b0, 32'h0000_0040);
        @(posedge sys_clk);
        #1;
        chk("ack_after", 32'h0, {31'h0, cfg_ack});
        chk("rdata_after", 32'h0, cfg_rdata);
        final_report();
    end
endmodule // mch_cfg_header_tb
